// ---- verilog/rclc_pkg.sv ----
// constants, state type and timing counts for the reel column loop control
// assumes one logic clock at CLK_KHZ and a single column sensor layout for both columns
`default_nettype none
package rclc_pkg;
    // per column: sensors above the middle zone and below it, ordered top to bottom
    localparam int ZONE_A_SENSORS = 6;
    localparam int ZONE_C_SENSORS = 5;
    localparam int COL_SENSORS = ZONE_A_SENSORS + ZONE_C_SENSORS;
    // midpoint sensor positions within each zone
    localparam int UPPER_MID_IDX = ZONE_A_SENSORS / 2;
    localparam int LOWER_MID_IDX = ZONE_A_SENSORS + ZONE_C_SENSORS / 2;
    // reel index: the right column feeds the file reel, the left the machine reel
    localparam int REEL_FILE = 0;
    localparam int REEL_MACH = 1;
    // driver bit positions in a reel's driver word
    localparam int DRV_A = 0;
    localparam int DRV_B = 1;
    localparam int DRV_C = 2;
    localparam int DRV_D = 3;
    localparam logic [3:0] DRV_OFF = 4'h0;
    localparam logic [3:0] DRV_BRAKED = 4'hC;
    localparam logic [3:0] DRV_HOLD = 4'h4;
    // clock and timing
    localparam int unsigned CLK_KHZ = 250000;
    localparam int unsigned ONESHOT_MS = 20;
    localparam int unsigned ONESHOT_CYCLES = ONESHOT_MS * CLK_KHZ;
    localparam int unsigned STAB_TERMINAL = 8;
    localparam int STAB_CW = 4;
    // per-reel control state
    typedef enum logic [1:0] {
        RCLC_BRAKE,
        RCLC_DRIVE,
        RCLC_COAST
    } rclc_reel_state_type;
endpackage
`default_nettype wire

// ---- verilog/rclc_one_shot.sv ----
// retriggerable velocity feedback one-shot with squelch
// assumes trigger and squelch are single-cycle pulses on mclk
`default_nettype none
module rclc_one_shot #(
    parameter int unsigned CYCLES = 5000000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic trigger,
    input wire logic squelch,
    output logic active
);
    import rclc_pkg::*;
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_r;

    // a new step restarts the period; retriggers inside it keep the pulse on
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= '0;
        else if (trigger)
            cnt_r <= CW'(CYCLES);
        else if (squelch)
            cnt_r <= '0;
        else if (cnt_r != '0)
            cnt_r <= cnt_r - CW'(1);
    end

    assign active = (cnt_r != '0);

    a_oneshot_fire: assert property (@(posedge mclk) disable iff (!rst_n)
        trigger |=> active ##1 (active || $past(squelch)))
        else $error("one-shot did not start on a step");

    a_squelch_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        squelch && !trigger |=> !active)
        else $error("one-shot not squelched");
endmodule // rclc_one_shot
`default_nettype wire

// ---- verilog/rclc_column_track.sv ----
// one vacuum column: sensor synchroniser, loop position, zone and motion steps
// assumes sensor bit 0 is the top sensor and a covered sensor reads 1
`default_nettype none
module rclc_column_track #(
    parameter int ZONE_A_N = 6,
    parameter int ZONE_C_N = 5
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ZONE_A_N+ZONE_C_N-1:0] sensors,
    input wire logic bottom_hit,
    input wire logic loaded_sense,
    output logic in_upper,
    output logic in_lower,
    output logic in_middle,
    output logic step_down,
    output logic step_up,
    output logic moving_down,
    output logic upper_mid_cov,
    output logic lower_mid_cov,
    output logic bottom_s,
    output logic loaded_s
);
    import rclc_pkg::*;
    localparam int N = ZONE_A_N + ZONE_C_N;
    localparam int CW = $clog2(N + 1);
    localparam logic [CW-1:0] A_CNT = CW'(ZONE_A_N);
    // idle pattern: loop resting in the middle zone, so reset release makes no false step
    localparam logic [N+1:0] SYNC_IDLE = {2'b00, {ZONE_C_N{1'b0}}, {ZONE_A_N{1'b1}}};
    logic [N+1:0] meta_r;
    logic [N+1:0] sync_r;
    logic [CW-1:0] pos_nxt;
    logic [CW-1:0] pos_r;
    logic [CW-1:0] prev_r;
    logic moving_down_r;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= SYNC_IDLE;
            sync_r <= SYNC_IDLE;
        end
        else
        begin
            meta_r <= {bottom_hit, loaded_sense, sensors};
            sync_r <= meta_r;
        end
    end

    // loop position is the number of covered sensors
    always_comb
    begin
        pos_nxt = '0;
        for (int k = 0; k < N; k++)
            pos_nxt = pos_nxt + CW'(sync_r[k]);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pos_r <= A_CNT;
            prev_r <= A_CNT;
            moving_down_r <= 1'b0;
        end
        else
        begin
            pos_r <= pos_nxt;
            prev_r <= pos_r;
            if (pos_r > prev_r)
                moving_down_r <= 1'b1;
            else if (pos_r < prev_r)
                moving_down_r <= 1'b0;
        end
    end

    assign step_down = (pos_r > prev_r);
    assign step_up = (pos_r < prev_r);
    // direction follows a step in the same cycle as the new position
    assign moving_down = step_down | (moving_down_r & ~step_up);
    assign in_upper = (pos_r < A_CNT);
    assign in_lower = (pos_r > A_CNT);
    assign in_middle = (pos_r == A_CNT);
    assign upper_mid_cov = sync_r[UPPER_MID_IDX];
    assign lower_mid_cov = sync_r[LOWER_MID_IDX];
    assign loaded_s = sync_r[N];
    assign bottom_s = sync_r[N+1];
endmodule // rclc_column_track
`default_nettype wire

// ---- verilog/rclc_top.sv ----
// column-mode reel control: zones to reel driver enables, feedback, faults, rewind
// assumes driver outputs feed the power gate directly; low-speed control lives elsewhere
`default_nettype none
module rclc_top
    import rclc_pkg::*;
#(
    parameter int unsigned ONESHOT_LEN = rclc_pkg::ONESHOT_CYCLES,
    parameter int unsigned STAB_COUNT = rclc_pkg::STAB_TERMINAL
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [rclc_pkg::COL_SENSORS-1:0] right_column_sensors,
    input wire logic [rclc_pkg::COL_SENSORS-1:0] left_column_sensors,
    input wire logic right_column_bottom_hit,
    input wire logic left_column_bottom_hit,
    input wire logic right_column_loaded_sense,
    input wire logic left_column_loaded_sense,
    input wire logic motion_request,
    input wire logic backward_request,
    input wire logic rewind_mode,
    input wire logic fast_reel_variant,
    input wire logic fault_clear,
    output logic file_reel_modulated_drive,
    output logic file_reel_drive_b,
    output logic file_reel_drive_c,
    output logic file_reel_drive_d,
    output logic machine_reel_drive_a,
    output logic machine_reel_modulated_drive,
    output logic machine_reel_drive_c,
    output logic machine_reel_drive_d,
    output logic file_reel_brake_cmd,
    output logic machine_reel_brake_cmd,
    output logic hold_current_driver_on,
    output logic low_speed_path_disable,
    output logic left_capstan_cutoff,
    output logic right_capstan_cutoff,
    output logic capstan_drive_enable,
    output logic tape_backward,
    output logic rewind_field_reduce,
    output logic file_reel_field_half,
    output logic machine_reel_field_half,
    output logic columns_loaded,
    output logic column_fault,
    output logic machine_fault
);
    import rclc_pkg::*;

    logic rst_s1_r;
    logic rst_n_i;
    logic [1:0] in_up, in_lo, in_mid, st_dn, st_up, mv_dn, umid, lmid, bot, ld;
    logic [1:0] dn_act, up_act, cut_cond, half_nxt;
    logic [1:0] cinh_r;
    logic loaded_r, col_fault_r, mach_fault_r, fault_ev, bwd;
    logic [STAB_CW-1:0] stab_cnt_r;
    logic stab_r;
    logic left_cut_r, right_cut_r, cap_en_r, bwd_r, rw_field_r;
    logic [1:0] half_r;
    logic [3:0] drv_r [2];
    logic brake_r [2];
    rclc_reel_state_type state_r [2];

    // reset release through two flip-flops
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_s1_r <= 1'b0;
            rst_n_i <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_i <= rst_s1_r;
        end
    end

    rclc_column_track #(.ZONE_A_N(ZONE_A_SENSORS), .ZONE_C_N(ZONE_C_SENSORS)) u_right_col (
        .mclk(mclk), .rst_n(rst_n_i), .sensors(right_column_sensors),
        .bottom_hit(right_column_bottom_hit), .loaded_sense(right_column_loaded_sense),
        .in_upper(in_up[REEL_FILE]), .in_lower(in_lo[REEL_FILE]),
        .in_middle(in_mid[REEL_FILE]), .step_down(st_dn[REEL_FILE]),
        .step_up(st_up[REEL_FILE]), .moving_down(mv_dn[REEL_FILE]),
        .upper_mid_cov(umid[REEL_FILE]), .lower_mid_cov(lmid[REEL_FILE]),
        .bottom_s(bot[REEL_FILE]), .loaded_s(ld[REEL_FILE])
    );

    rclc_column_track #(.ZONE_A_N(ZONE_A_SENSORS), .ZONE_C_N(ZONE_C_SENSORS)) u_left_col (
        .mclk(mclk), .rst_n(rst_n_i), .sensors(left_column_sensors),
        .bottom_hit(left_column_bottom_hit), .loaded_sense(left_column_loaded_sense),
        .in_upper(in_up[REEL_MACH]), .in_lower(in_lo[REEL_MACH]),
        .in_middle(in_mid[REEL_MACH]), .step_down(st_dn[REEL_MACH]),
        .step_up(st_up[REEL_MACH]), .moving_down(mv_dn[REEL_MACH]),
        .upper_mid_cov(umid[REEL_MACH]), .lower_mid_cov(lmid[REEL_MACH]),
        .bottom_s(bot[REEL_MACH]), .loaded_s(ld[REEL_MACH])
    );

    // rewind forces backward motion
    assign bwd = backward_request | rewind_mode;

    // loaded latch and fault latches; a fault event wins over fault_clear
    assign fault_ev = (|bot) | (loaded_r & ~(&ld));

    always_ff @(posedge mclk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            loaded_r <= 1'b0;
            col_fault_r <= 1'b0;
            mach_fault_r <= 1'b0;
        end
        else
        begin
            if (fault_ev)
                loaded_r <= 1'b0;
            else if ((&ld) && !col_fault_r)
                loaded_r <= 1'b1;
            col_fault_r <= fault_ev | (col_fault_r & ~fault_clear);
            mach_fault_r <= fault_ev | (mach_fault_r & ~fault_clear);
        end
    end

    // loop stabilisation delay after the motion request drops
    always_ff @(posedge mclk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stab_cnt_r <= '0;
            stab_r <= 1'b0;
        end
        else if (motion_request)
        begin
            stab_cnt_r <= '0;
            stab_r <= 1'b0;
        end
        else if (stab_cnt_r == STAB_CW'(STAB_COUNT - 1))
            stab_r <= 1'b1;
        else
            stab_cnt_r <= stab_cnt_r + STAB_CW'(1);
    end

    // velocity feedback one-shots per column, each squelched by the other
    for (genvar c = 0; c < 2; c++)
    begin : g_fb
        rclc_one_shot #(.CYCLES(ONESHOT_LEN)) u_down (
            .mclk(mclk), .rst_n(rst_n_i), .trigger(st_dn[c]), .squelch(st_up[c]),
            .active(dn_act[c])
        );
        rclc_one_shot #(.CYCLES(ONESHOT_LEN)) u_up (
            .mclk(mclk), .rst_n(rst_n_i), .trigger(st_up[c]), .squelch(st_dn[c]),
            .active(up_act[c])
        );
    end

    // rewind cutouts: left loop above upper midpoint, right loop below lower midpoint
    assign cut_cond[REEL_MACH] = rewind_mode & loaded_r & ~umid[REEL_MACH];
    assign cut_cond[REEL_FILE] = rewind_mode & loaded_r & lmid[REEL_FILE];

    // zone-half field reduction, suppressed during rewind
    for (genvar f = 0; f < 2; f++)
    begin : g_half
        assign half_nxt[f] = fast_reel_variant & ~rewind_mode & loaded_r
            & ((in_up[f] & ~umid[f]) | (in_lo[f] & lmid[f]));
    end

    always_ff @(posedge mclk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            left_cut_r <= 1'b0;
            right_cut_r <= 1'b0;
            cap_en_r <= 1'b0;
            bwd_r <= 1'b0;
            rw_field_r <= 1'b0;
            half_r <= 2'h0;
        end
        else
        begin
            left_cut_r <= cut_cond[REEL_MACH];
            right_cut_r <= cut_cond[REEL_FILE];
            cap_en_r <= motion_request & loaded_r & ~(|cut_cond);
            bwd_r <= bwd;
            rw_field_r <= rewind_mode;
            half_r <= half_nxt;
        end
    end

    // per-reel drive, coast and brake control
    for (genvar i = 0; i < 2; i++)
    begin : g_reel
        logic upper_reg, reg_zone, toward_mid, inhibit, fb_pulse;
        rclc_reel_state_type state_nxt;
        logic [3:0] drv_nxt;

        // which zone this reel regulates depends on tape direction
        assign upper_reg = (i == REEL_FILE) ? ~bwd : bwd;
        assign reg_zone = upper_reg ? in_up[i] : in_lo[i];
        assign toward_mid = upper_reg ? mv_dn[i] : ~mv_dn[i];
        assign inhibit = upper_reg ? (dn_act[i] & in_up[i]) : (up_act[i] & in_lo[i]);
        assign fb_pulse = upper_reg ? dn_act[i] : up_act[i];

        always_ff @(posedge mclk or negedge rst_n_i)
        begin
            if (!rst_n_i)
                cinh_r[i] <= 1'b0;
            else
                cinh_r[i] <= cut_cond[i] | (cinh_r[i] & ~in_mid[i]);
        end

        always_comb
        begin
            state_nxt = state_r[i];
            if (!loaded_r)
                state_nxt = RCLC_BRAKE;
            else if (reg_zone)
            begin
                // coast only while a feedback pulse runs; a still loop drives again after it
                if (toward_mid && fb_pulse && !cinh_r[i])
                    state_nxt = RCLC_COAST;
                else
                    state_nxt = RCLC_DRIVE;
            end
            else
                state_nxt = RCLC_BRAKE;
        end

        always_comb
        begin
            drv_nxt = DRV_OFF;
            if (!loaded_r)
                drv_nxt = DRV_BRAKED;
            else if (stab_r && state_r[i] == RCLC_BRAKE)
                drv_nxt = DRV_HOLD;
            else
            begin
                case (state_r[i])
                    RCLC_DRIVE:
                    begin
                        // coast inhibit holds the modulated driver on against pulses
                        if (upper_reg)
                        begin
                            drv_nxt[DRV_A] = ~inhibit | cinh_r[i];
                            drv_nxt[DRV_D] = 1'b1;
                        end
                        else
                        begin
                            drv_nxt[DRV_B] = ~inhibit | cinh_r[i];
                            drv_nxt[DRV_C] = 1'b1;
                        end
                    end
                    RCLC_COAST:
                    begin
                        if (upper_reg)
                            drv_nxt[DRV_D] = 1'b1;
                        else
                            drv_nxt[DRV_C] = 1'b1;
                    end
                    RCLC_BRAKE:
                    begin
                        if (upper_reg)
                            drv_nxt[DRV_C] = 1'b1;
                        else
                            drv_nxt[DRV_D] = 1'b1;
                    end
                    default:
                        drv_nxt = DRV_BRAKED;
                endcase
            end
        end

        always_ff @(posedge mclk or negedge rst_n_i)
        begin
            if (!rst_n_i)
            begin
                state_r[i] <= RCLC_BRAKE;
                drv_r[i] <= DRV_BRAKED;
                brake_r[i] <= 1'b0;
            end
            else
            begin
                state_r[i] <= state_nxt;
                drv_r[i] <= drv_nxt;
                brake_r[i] <= loaded_r & ~stab_r & (state_r[i] == RCLC_BRAKE);
            end
        end

        a_drive_to_brake: assert property (@(posedge mclk) disable iff (!rst_n_i)
            loaded_r && !fault_ev && in_mid[i] |=> state_r[i] == RCLC_BRAKE)
            else $error("reel did not brake on entering middle zone");

        a_coast_inhibit_hold: assert property (@(posedge mclk) disable iff (!rst_n_i)
            cinh_r[i] && !in_mid[i] |=> cinh_r[i])
            else $error("coast inhibit released outside middle zone");
    end

    assign file_reel_modulated_drive = drv_r[REEL_FILE][DRV_A];
    assign file_reel_drive_b = drv_r[REEL_FILE][DRV_B];
    assign file_reel_drive_c = drv_r[REEL_FILE][DRV_C];
    assign file_reel_drive_d = drv_r[REEL_FILE][DRV_D];
    assign machine_reel_drive_a = drv_r[REEL_MACH][DRV_A];
    assign machine_reel_modulated_drive = drv_r[REEL_MACH][DRV_B];
    assign machine_reel_drive_c = drv_r[REEL_MACH][DRV_C];
    assign machine_reel_drive_d = drv_r[REEL_MACH][DRV_D];
    assign file_reel_brake_cmd = brake_r[REEL_FILE];
    assign machine_reel_brake_cmd = brake_r[REEL_MACH];
    assign hold_current_driver_on = stab_r;
    assign low_speed_path_disable = stab_r;
    assign left_capstan_cutoff = left_cut_r;
    assign right_capstan_cutoff = right_cut_r;
    assign capstan_drive_enable = cap_en_r;
    assign tape_backward = bwd_r;
    assign rewind_field_reduce = rw_field_r;
    assign file_reel_field_half = half_r[REEL_FILE];
    assign machine_reel_field_half = half_r[REEL_MACH];
    assign columns_loaded = loaded_r;
    assign column_fault = col_fault_r;
    assign machine_fault = mach_fault_r;

    a_fault_bottom: assert property (@(posedge mclk) disable iff (!rst_n_i)
        |bot |=> col_fault_r && mach_fault_r && !loaded_r)
        else $error("bottom sensor did not raise a column fault");

    a_fault_uncover: assert property (@(posedge mclk) disable iff (!rst_n_i)
        loaded_r && !(&ld) |=> !loaded_r && col_fault_r && mach_fault_r)
        else $error("loaded sensor uncover did not drop the loaded latch");

    a_stab_delay: assert property (@(posedge mclk) disable iff (!rst_n_i)
        motion_request ##1 !motion_request [*8] |=> stab_r)
        else $error("stabilisation not reached at terminal count");

    a_stab_early: assert property (@(posedge mclk) disable iff (!rst_n_i)
        motion_request ##1 !motion_request [*7] |=> !stab_r)
        else $error("stabilisation reached too early");

    a_hold_degate: assert property (@(posedge mclk) disable iff (!rst_n_i)
        stab_r && !motion_request && loaded_r && state_r[REEL_FILE] == RCLC_BRAKE
        |=> hold_current_driver_on && low_speed_path_disable && !file_reel_drive_d)
        else $error("hold state did not drop driver D");

    a_left_cutout: assert property (@(posedge mclk) disable iff (!rst_n_i)
        rewind_mode && loaded_r && !umid[REEL_MACH]
        |=> left_capstan_cutoff && !capstan_drive_enable)
        else $error("left cutout missing in rewind");

    a_right_cutout: assert property (@(posedge mclk) disable iff (!rst_n_i)
        rewind_mode && loaded_r && lmid[REEL_FILE]
        |=> right_capstan_cutoff && !capstan_drive_enable)
        else $error("right cutout missing in rewind");

    a_rewind_field: assert property (@(posedge mclk) disable iff (!rst_n_i)
        rewind_mode |=> rewind_field_reduce && tape_backward
            && !file_reel_field_half && !machine_reel_field_half)
        else $error("rewind field or direction wrong");

    a_unloaded_braked: assert property (@(posedge mclk) disable iff (!rst_n_i)
        !loaded_r |=> drv_r[REEL_FILE] == DRV_BRAKED && drv_r[REEL_MACH] == DRV_BRAKED)
        else $error("drivers active without loaded columns");
endmodule // rclc_top
`default_nettype wire

// ---- test/rclc_column_model.sv ----
// column model: a loop at a given depth covers every sensor above it
// assumes depth counts covered sensors from the top, bit 0 being the top
`default_nettype none
module rclc_column_model
    import rclc_pkg::*;
(
    input wire logic [3:0] depth,
    output logic [rclc_pkg::COL_SENSORS-1:0] sensors
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb
    begin
        for (int i = 0; i < COL_SENSORS; i++)
        begin
            sensors[i] = (i < depth);
        end
    end
endmodule // rclc_column_model
`default_nettype wire

// ---- test/rclc_top_bench.sv ----
// self-checking bench: loop depths in, reel driver words and latches compared
// assumes a short one-shot count, the default stabilisation count of 8, inputs driven on falling edges
`default_nettype none
module rclc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rclc_pkg::*;
    logic mclk, reset_n, right_column_bottom_hit, left_column_bottom_hit;
    logic right_column_loaded_sense, left_column_loaded_sense, motion_request;
    logic backward_request, rewind_mode, fast_reel_variant, fault_clear;
    logic [3:0] rdep, ldep;
    logic [COL_SENSORS-1:0] right_column_sensors, left_column_sensors;
    logic file_reel_modulated_drive, file_reel_drive_b, file_reel_drive_c, file_reel_drive_d;
    logic machine_reel_drive_a, machine_reel_modulated_drive, machine_reel_drive_c;
    logic machine_reel_drive_d, file_reel_brake_cmd, machine_reel_brake_cmd;
    logic hold_current_driver_on, low_speed_path_disable, left_capstan_cutoff;
    logic right_capstan_cutoff, capstan_drive_enable, tape_backward, rewind_field_reduce;
    logic file_reel_field_half, machine_reel_field_half, columns_loaded, column_fault;
    logic machine_fault;
    logic [3:0] fr, ml;
    int fails, compares, n;
    assign fr = {file_reel_modulated_drive, file_reel_drive_b, file_reel_drive_c,
        file_reel_drive_d};
    assign ml = {machine_reel_drive_a, machine_reel_modulated_drive, machine_reel_drive_c,
        machine_reel_drive_d};
    rclc_column_model i_rclc_column_model_r (.depth(rdep), .sensors(right_column_sensors));
    rclc_column_model i_rclc_column_model_l (.depth(ldep), .sensors(left_column_sensors));
    rclc_top #(.ONESHOT_LEN(20), .STAB_COUNT(8)) i_rclc_top (.mclk, .reset_n,
        .right_column_sensors, .left_column_sensors, .right_column_bottom_hit,
        .left_column_bottom_hit, .right_column_loaded_sense, .left_column_loaded_sense,
        .motion_request, .backward_request, .rewind_mode, .fast_reel_variant, .fault_clear,
        .file_reel_modulated_drive, .file_reel_drive_b, .file_reel_drive_c, .file_reel_drive_d,
        .machine_reel_drive_a, .machine_reel_modulated_drive, .machine_reel_drive_c,
        .machine_reel_drive_d, .file_reel_brake_cmd, .machine_reel_brake_cmd,
        .hold_current_driver_on, .low_speed_path_disable, .left_capstan_cutoff,
        .right_capstan_cutoff, .capstan_drive_enable, .tape_backward, .rewind_field_reduce,
        .file_reel_field_half, .machine_reel_field_half, .columns_loaded, .column_fault,
        .machine_fault);
    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // new depths, then enough cycles for sync, position and driver update
    task automatic step(input logic [3:0] r, input logic [3:0] l);
        rdep = r;
        ldep = l;
        repeat (8) @(negedge mclk);
    endtask
    task end_of_test;
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        mclk = 0;
        forever #2 mclk = ~mclk;
    end
    initial
    begin
        {reset_n, right_column_bottom_hit, left_column_bottom_hit, motion_request} = '0;
        {right_column_loaded_sense, left_column_loaded_sense, backward_request} = '0;
        {rewind_mode, fast_reel_variant, fault_clear, fails, compares} = '0;
        rdep = 6;
        ldep = 6;
        repeat (8) @(negedge mclk);
        reset_n = 1;
        step(6, 6);
        chk("unloaded right", 4'h3, fr);
        {right_column_loaded_sense, left_column_loaded_sense, motion_request} = 3'h7;
        step(6, 6);
        chk("loaded", 4'h1, columns_loaded);
        step(4, 8);
        chk("right drive", 4'h9, fr);
        chk("left drive", 4'h6, ml);
        fast_reel_variant = 1;
        step(3, 9);
        chk("right deeper", 4'h9, fr);
        chk("left deeper", 4'h6, ml);
        chk("field half", 4'h3, {file_reel_field_half, machine_reel_field_half});
        step(4, 8);
        chk("right coast", 4'h1, fr);
        chk("left coast", 4'h2, ml);
        step(3, 9);
        chk("right squelch", 4'h9, fr);
        chk("left squelch", 4'h6, ml);
        step(6, 6);
        chk("right brake", 4'h2, fr);
        chk("left brake", 4'h1, ml);
        chk("brake cmds", 4'h3, {file_reel_brake_cmd, machine_reel_brake_cmd});
        motion_request = 0;
        n = 0;
        while (hold_current_driver_on !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        chk("stab delay", 4'h8, n[3:0]);
        @(negedge mclk);
        chk("right hold", 4'h2, fr);
        chk("left hold", 4'h2, ml);
        chk("brakes off", 4'h0, {file_reel_brake_cmd, machine_reel_brake_cmd});
        chk("degate", 4'h1, low_speed_path_disable);
        {motion_request, backward_request} = 2'h3;
        step(8, 4);
        chk("right backward", 4'h6, fr);
        chk("left backward", 4'h9, ml);
        backward_request = 0;
        step(6, 6);
        {motion_request, rewind_mode} = 2'h3;
        step(6, 6);
        chk("rewind", 4'h3, {tape_backward, rewind_field_reduce});
        step(6, 3);
        chk("left cutout", 4'h2, {left_capstan_cutoff, capstan_drive_enable});
        chk("rewind half", 4'h0, {file_reel_field_half, machine_reel_field_half});
        step(6, 6);
        chk("left resume", 4'h1, {left_capstan_cutoff, capstan_drive_enable});
        step(9, 6);
        chk("right cutout", 4'h2, {right_capstan_cutoff, capstan_drive_enable});
        step(6, 6);
        right_column_bottom_hit = 1;
        step(6, 6);
        chk("bottom fault", 4'h3, {columns_loaded, column_fault, machine_fault});
        {right_column_bottom_hit, fault_clear} = 2'h1;
        step(6, 6);
        fault_clear = 0;
        step(6, 6);
        chk("reloaded", 4'h4, {columns_loaded, column_fault, machine_fault});
        left_column_loaded_sense = 0;
        step(6, 6);
        chk("loaded lost", 4'h3, {columns_loaded, column_fault, machine_fault});
        end_of_test;
    end
endmodule // rclc_top_bench
`default_nettype wire
